// ===== rtl/pamx_regs.svh
// Constants for the port A alternate function mux.
// Assumes inclusion by bare name from files under rtl/.
`ifndef PAMX_REGS_SVH
`define PAMX_REGS_SVH

// Port width and pin positions of the alternate functions
`define PAMX_NUM_PINS 8
`define PAMX_PIN_REF 0
`define PAMX_PIN_CMP_POS 1
`define PAMX_PIN_CMP_NEG 2
`define PAMX_PIN_CNT0 3
`define PAMX_PIN_SCLK 4
`define PAMX_PIN_DO 5
`define PAMX_PIN_SDA 6
`define PAMX_PIN_ICP 7

// Wire-mode code that selects three-wire operation
`define PAMX_WM_THREE_WIRE 2'h1

// Reset values of the registered pad controls
`define PAMX_RST_DRIVE 8'h00
`define PAMX_RST_OE_N 8'hff
`define PAMX_RST_PULLUP 8'h00
`define PAMX_RST_INPUT_EN 8'h00

`endif

// ===== rtl/pamx_pkg.sv
// Types shared by the port A alternate function mux.
// Assumes pamx_regs.svh holds the matching constants.
package pamx_pkg;

   // Override bundle for one pin
   typedef struct packed {
      logic pullup_override_enable;
      logic pullup_override_value;
      logic direction_override_enable;
      logic direction_override_value;
      logic port_value_override_enable;
      logic port_value_override_value;
      logic toggle_override_enable;
      logic input_enable_override_enable;
      logic input_enable_override_value;
   } pamx_ovr_type;

   // Peripheral configuration bits that steer the overrides
   typedef struct packed {
      logic reference_select_bit0;
      logic wire_mode_bit1;
      logic wire_mode_bit0;
      logic start_condition_int_enable;
      logic pin_change_group0_enable;
      logic [7:0] pin_change_mask;
      logic [7:0] analog_input_digital_disable;
      logic timer1_compare_a_en;
      logic timer1_compare_b_en;
      logic timer0_compare_b_en;
   } pamx_ctrl_type;

   // Output signals of the peripherals
   typedef struct packed {
      logic timer1_compare_a_out;
      logic timer1_compare_b_out;
      logic timer0_compare_b_out;
      logic serial_data_out;
      logic two_wire_data_out;
   } pamx_periph_out_type;

   // Normal port register bits
   typedef struct packed {
      logic [7:0] port_value;
      logic [7:0] direction;
      logic pullup_disable;
      logic sleep;
   } pamx_port_type;

   // Controls toward the pads
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] output_enable_n;
      logic [7:0] pullup_enable;
      logic [7:0] input_enable;
   } pamx_pad_bus_type;

   // Pin signals toward the peripherals
   typedef struct packed {
      logic [7:0] pin_change_source;
      logic [7:0] converter_channel;
      logic timer0_count_input;
      logic timer1_count_input;
      logic serial_clock_three_wire;
      logic serial_data_in_three_wire;
      logic timer1_capture_input;
      logic comparator_positive_input;
      logic comparator_negative_input;
   } pamx_periph_in_type;

   // Whole registered state of the mux
   typedef struct packed {
      pamx_pad_bus_type pad;
      pamx_periph_in_type periph;
   } pamx_state_type;

endpackage

// ===== rtl/pamx_pin.sv
// Generic override combiner for one port pin.
// Assumes the caller registers the results; purely combinational.
`timescale 1ns/1ps
module pamx_pin
   import pamx_pkg::*;
(
   input wire pamx_ovr_type i_ovr,
   input wire logic i_port_value,
   input wire logic i_direction,
   input wire logic i_pullup_disable,
   input wire logic i_sleep,
   input wire logic i_pad_level,
   output logic o_drive,
   output logic o_output_enable_n,
   output logic o_pullup_enable,
   output logic o_input_enable,
   output logic o_digital_in
);

   logic driver_on;
   logic port_bit;

   // Output driver and driven value
   always_comb begin
      if (i_ovr.direction_override_enable) begin
         driver_on = i_ovr.direction_override_value; // see RULE20
      end else begin
         driver_on = i_direction;
      end
      port_bit = i_ovr.toggle_override_enable ? ~i_port_value : i_port_value;
      if (i_ovr.port_value_override_enable && driver_on) begin
         o_drive = i_ovr.port_value_override_value; // see RULE19
      end else begin
         o_drive = port_bit;
      end
      o_output_enable_n = ~driver_on;
   end

   // Pull-up; the plain case needs input direction and no global disable
   always_comb begin
      if (i_ovr.pullup_override_enable) begin
         o_pullup_enable = i_ovr.pullup_override_value;
      end else begin
         o_pullup_enable = ~i_direction & i_port_value & ~i_pullup_disable;
      end
   end

   // Input enable; sleep clamps unless an alternate function needs the pin
   always_comb begin
      if (i_ovr.input_enable_override_enable) begin
         o_input_enable = i_ovr.input_enable_override_value; // see RULE21
      end else begin
         o_input_enable = ~i_sleep;
      end
      o_digital_in = i_pad_level & o_input_enable;
   end

endmodule

// ===== rtl/pamx_top.sv
// Port A alternate function mux: overrides and pin routing for eight pins.
// Assumes pad levels and peripheral signals are synchronous to i_core_clk.
//
// What this block does
// RULE1 - Pin n analog path feeds converter channel n
// RULE2 - Reference select releases pull-up and driver pin 0
// RULE3 - Pin n feeds pin change source n
// RULE4 - Software: comparator pins input, pull-up off
// RULE5 - Pin 3 input counts timer 0
// RULE6 - Pin 4 is serial clock and timer 1 count
// RULE7 - Three-wire data out drives pin 5 when output
// RULE8 - Pin 5 port bit still controls its pull-up
// RULE9 - Software sets direction before compare outputs appear
// RULE10 - Software makes pin 6 input for serial data
// RULE11 - Pin 7 input feeds timer 1 capture
// RULE12 - Pin 6 open-drain direction under wire mode
// RULE13 - Pin 6 value is compare A, gated by two-wire
// RULE14 - Pin 5 value is serial out or compare B
// RULE15 - Pin 7 value is timer 0 compare B
// RULE16 - Pin 6 input enable includes start-condition enable
// RULE17 - Pins 5, 7 input enable from pin-change, disable
// RULE18 - Pins 5 to 7 never override pull-up or toggle
// RULE19 - Port value override replaces port bit when driving
// RULE20 - Direction override replaces direction bit
// RULE21 - Input enable override beats sleep state
`include "pamx_regs.svh"
`timescale 1ns/1ps
module pamx_top
   import pamx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire pamx_port_type i_port,
   input wire pamx_ctrl_type i_ctrl,
   input wire pamx_periph_out_type i_periph,
   input wire logic [7:0] i_pad_level,
   output pamx_pad_bus_type o_pad,
   output pamx_periph_in_type o_periph
);

   pamx_state_type state_q;
   pamx_state_type state_d;
   pamx_ovr_type [7:0] ovr;
   logic [7:0] pin_drive;
   logic [7:0] pin_oe_n;
   logic [7:0] pin_pullup;
   logic [7:0] pin_input_en;
   logic [7:0] pin_digital;
   logic three_wire;
   logic pc_term5;
   logic pc_term6;
   logic pc_term7;
   logic sda_hold;

   // Three-wire decode and pin-change terms used by several pins
   assign three_wire = ({i_ctrl.wire_mode_bit1, i_ctrl.wire_mode_bit0} ==
                        `PAMX_WM_THREE_WIRE);
   assign pc_term5 = i_ctrl.pin_change_mask[`PAMX_PIN_DO] & i_ctrl.pin_change_group0_enable;
   assign pc_term6 = i_ctrl.pin_change_mask[`PAMX_PIN_SDA] & i_ctrl.pin_change_group0_enable;
   assign pc_term7 = i_ctrl.pin_change_mask[`PAMX_PIN_ICP] & i_ctrl.pin_change_group0_enable;
   assign sda_hold = i_ctrl.wire_mode_bit1 & i_port.direction[`PAMX_PIN_SDA];

   // Override signals per pin; every field starts at zero
   always_comb begin
      ovr = '0;
      // Low pins keep the plain pin-change input enable
      for (int n = 0; n < 5; n++) begin
         ovr[n].input_enable_override_enable =
            (i_ctrl.pin_change_mask[n] & i_ctrl.pin_change_group0_enable) |
            i_ctrl.analog_input_digital_disable[n];
         ovr[n].input_enable_override_value =
            i_ctrl.pin_change_mask[n] & i_ctrl.pin_change_group0_enable;
      end
      // External reference use frees pin 0 from pull-up and driver
      ovr[`PAMX_PIN_REF].pullup_override_enable = i_ctrl.reference_select_bit0; // see RULE2
      ovr[`PAMX_PIN_REF].direction_override_enable = i_ctrl.reference_select_bit0; // see RULE2
      ovr[`PAMX_PIN_REF].port_value_override_enable = i_ctrl.reference_select_bit0;
      // Serial clock pin also listens for the start condition
      ovr[`PAMX_PIN_SCLK].input_enable_override_enable =
         ovr[`PAMX_PIN_SCLK].input_enable_override_enable |
         i_ctrl.start_condition_int_enable;
      ovr[`PAMX_PIN_SCLK].input_enable_override_value =
         ovr[`PAMX_PIN_SCLK].input_enable_override_value |
         i_ctrl.start_condition_int_enable;
      // Pin 5: serial data out or timer 1 compare B
      ovr[`PAMX_PIN_DO].port_value_override_enable =
         three_wire | i_ctrl.timer1_compare_b_en; // see RULE14
      ovr[`PAMX_PIN_DO].port_value_override_value =
         three_wire ? i_periph.serial_data_out : i_periph.timer1_compare_b_out; // see RULE7
      ovr[`PAMX_PIN_DO].input_enable_override_enable =
         pc_term5 | i_ctrl.analog_input_digital_disable[`PAMX_PIN_DO]; // see RULE17
      ovr[`PAMX_PIN_DO].input_enable_override_value = pc_term5; // see RULE17
      // Pin 6: open-drain two-wire data or timer 1 compare A
      ovr[`PAMX_PIN_SDA].direction_override_enable = i_ctrl.wire_mode_bit1; // see RULE12
      ovr[`PAMX_PIN_SDA].direction_override_value =
         (~i_periph.two_wire_data_out | ~i_port.port_value[`PAMX_PIN_SDA]) &
         i_port.direction[`PAMX_PIN_SDA]; // see RULE12
      ovr[`PAMX_PIN_SDA].port_value_override_enable =
         sda_hold | i_ctrl.timer1_compare_a_en; // see RULE13
      ovr[`PAMX_PIN_SDA].port_value_override_value =
         ~sda_hold & i_periph.timer1_compare_a_out; // see RULE13
      ovr[`PAMX_PIN_SDA].input_enable_override_enable =
         i_ctrl.start_condition_int_enable | pc_term6 |
         i_ctrl.analog_input_digital_disable[`PAMX_PIN_SDA]; // see RULE16
      ovr[`PAMX_PIN_SDA].input_enable_override_value =
         i_ctrl.start_condition_int_enable | pc_term6; // see RULE16
      // Pin 7: timer 0 compare B
      ovr[`PAMX_PIN_ICP].port_value_override_enable = i_ctrl.timer0_compare_b_en; // see RULE15
      ovr[`PAMX_PIN_ICP].port_value_override_value = i_periph.timer0_compare_b_out; // see RULE15
      ovr[`PAMX_PIN_ICP].input_enable_override_enable =
         pc_term7 | i_ctrl.analog_input_digital_disable[`PAMX_PIN_ICP]; // see RULE17
      ovr[`PAMX_PIN_ICP].input_enable_override_value = pc_term7; // see RULE17
      // Pull-up stays with the port bit on the upper pins; see RULE8
      for (int n = 5; n < 8; n++) begin
         ovr[n].pullup_override_enable = 1'b0; // see RULE18
         ovr[n].pullup_override_value = 1'b0; // see RULE18
         ovr[n].toggle_override_enable = 1'b0; // see RULE18
      end
   end

   // One combiner per pin
   genvar g;
   generate
      for (g = 0; g < `PAMX_NUM_PINS; g++) begin : gen_pin
         pamx_pin u_pin (
            .i_ovr(ovr[g]),
            .i_port_value(i_port.port_value[g]),
            .i_direction(i_port.direction[g]),
            .i_pullup_disable(i_port.pullup_disable),
            .i_sleep(i_port.sleep),
            .i_pad_level(i_pad_level[g]),
            .o_drive(pin_drive[g]),
            .o_output_enable_n(pin_oe_n[g]),
            .o_pullup_enable(pin_pullup[g]),
            .o_input_enable(pin_input_en[g]),
            .o_digital_in(pin_digital[g])
         );
      end
   endgenerate

   // Next state: pad controls and peripheral-side routing
   always_comb begin
      state_d = state_q;
      state_d.pad.drive = pin_drive;
      state_d.pad.output_enable_n = pin_oe_n;
      state_d.pad.pullup_enable = pin_pullup;
      state_d.pad.input_enable = pin_input_en;
      // Analog path is unclamped; the pad level stands in for the voltage
      state_d.periph.converter_channel = i_pad_level; // see RULE1
      state_d.periph.pin_change_source = pin_digital; // see RULE3
      state_d.periph.comparator_positive_input = i_pad_level[`PAMX_PIN_CMP_POS];
      state_d.periph.comparator_negative_input = i_pad_level[`PAMX_PIN_CMP_NEG];
      state_d.periph.timer0_count_input = pin_digital[`PAMX_PIN_CNT0]; // see RULE5
      state_d.periph.serial_clock_three_wire = pin_digital[`PAMX_PIN_SCLK]; // see RULE6
      state_d.periph.timer1_count_input = pin_digital[`PAMX_PIN_SCLK]; // see RULE6
      // Data input needs pin 6 set as input by software; see RULE10
      state_d.periph.serial_data_in_three_wire = pin_digital[`PAMX_PIN_SDA];
      state_d.periph.timer1_capture_input = pin_digital[`PAMX_PIN_ICP]; // see RULE11
      if (i_rst) begin
         state_d = '0;
         state_d.pad.drive = `PAMX_RST_DRIVE;
         state_d.pad.output_enable_n = `PAMX_RST_OE_N;
         state_d.pad.pullup_enable = `PAMX_RST_PULLUP;
         state_d.pad.input_enable = `PAMX_RST_INPUT_EN;
      end
   end

   // Register everything; one cycle of latency buys glitch-free pads
   always_ff @(posedge i_core_clk) begin
      state_q <= state_d;
   end

   assign o_pad = state_q.pad;
   assign o_periph = state_q.periph;

   // Checks on the registered outputs, one cycle after their cause
   a_adc_channel_map: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE1
      !$past(i_rst) |-> o_periph.converter_channel == $past(i_pad_level))
      else $error("converter channel does not follow its pin");

   a_ref_pin_release: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE2
      $past(i_ctrl.reference_select_bit0) && !$past(i_rst) |->
      o_pad.output_enable_n[0] && !o_pad.pullup_enable[0])
      else $error("pin 0 driven or pulled up under external reference");

   a_pcint_clamped: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE3
      !$past(i_rst) |->
      o_periph.pin_change_source == ($past(i_pad_level) & o_pad.input_enable))
      else $error("pin change source differs from clamped pin input");

   a_timer_inputs: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE5
      !$past(i_rst) |->
      o_periph.timer0_count_input == ($past(i_pad_level[3]) & o_pad.input_enable[3]) &&
      o_periph.timer1_capture_input == ($past(i_pad_level[7]) & o_pad.input_enable[7]))
      else $error("timer input not routed from its pin");

   a_serial_clock_pin: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE6
      !$past(i_rst) |->
      o_periph.serial_clock_three_wire == ($past(i_pad_level[4]) & o_pad.input_enable[4]) &&
      o_periph.timer1_count_input == ($past(i_pad_level[4]) & o_pad.input_enable[4]))
      else $error("pin 4 not routed to serial clock and timer 1");

   a_do_drive: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE7
      !$past(i_rst) && $past(three_wire) && $past(i_port.direction[5]) |->
      !o_pad.output_enable_n[5] && o_pad.drive[5] == $past(i_periph.serial_data_out))
      else $error("pin 5 does not drive serial data out");

   a_do_pullup: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE8
      !$past(i_rst) && $past(three_wire) |->
      o_pad.pullup_enable[5] == $past(~i_port.direction[5] & i_port.port_value[5] &
                                      ~i_port.pullup_disable))
      else $error("pin 5 pull-up not taken from port bit");

   a_sda_open_drain: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE12
      !$past(i_rst) && $past(i_ctrl.wire_mode_bit1) |->
      o_pad.output_enable_n[6] == !$past((~i_periph.two_wire_data_out |
         ~i_port.port_value[6]) & i_port.direction[6]))
      else $error("pin 6 direction not open-drain in two-wire mode");

   // Drive value only counts while the driver is on; open-drain release shows the port bit
   a_cmp1a_value: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE13
      !$past(i_rst) && $past(i_ctrl.timer1_compare_a_en) && $past(i_port.direction[6]) |->
      o_pad.output_enable_n[6] || o_pad.drive[6] == ($past(i_periph.timer1_compare_a_out) &&
         !$past(i_ctrl.wire_mode_bit1)))
      else $error("pin 6 value not compare A gated by two-wire");

   a_cmp1b_value: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE14
      !$past(i_rst) && !$past(three_wire) && $past(i_ctrl.timer1_compare_b_en) &&
      $past(i_port.direction[5]) |->
      o_pad.drive[5] == $past(i_periph.timer1_compare_b_out))
      else $error("pin 5 value not compare B");

   a_cmp0b_value: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE15
      !$past(i_rst) && $past(i_ctrl.timer0_compare_b_en) && $past(i_port.direction[7]) |->
      !o_pad.output_enable_n[7] && o_pad.drive[7] == $past(i_periph.timer0_compare_b_out))
      else $error("pin 7 value not timer 0 compare B");

   a_start_cond_wake: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE16
      !$past(i_rst) && $past(i_ctrl.start_condition_int_enable) |->
      o_pad.input_enable[6] && o_pad.input_enable[4])
      else $error("start-condition enable does not open pin 6 input");

   a_digital_disable: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE17
      !$past(i_rst) && $past(i_ctrl.analog_input_digital_disable[7]) && !$past(pc_term7) |->
      !o_pad.input_enable[7])
      else $error("pin 7 input not disabled by analog disable bit");

   a_upper_pullup: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE18
      !$past(i_rst) && $past(i_port.direction[7]) |-> !o_pad.pullup_enable[7])
      else $error("pin 7 pulled up while output");

   a_sleep_override: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE21
      !$past(i_rst) && $past(i_port.sleep) && !$past(ovr[3].input_enable_override_enable) |->
      !o_pad.input_enable[3])
      else $error("pin 3 input open during sleep without override");

   a_plain_direction: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE20
      !$past(i_rst) |-> o_pad.output_enable_n[1] == !$past(i_port.direction[1]))
      else $error("pin 1 driver does not follow its direction bit");

   // Pin 5 stays undriven as an input even in three-wire mode
   a_do_input_hiz: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE7
      !$past(i_rst) && $past(three_wire) && !$past(i_port.direction[5]) |->
      o_pad.output_enable_n[5])
      else $error("pin 5 driven while its direction is input");

   a_plain_drive7: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE19
      !$past(i_rst) && !$past(i_ctrl.timer0_compare_b_en) && $past(i_port.direction[7]) |->
      o_pad.drive[7] == $past(i_port.port_value[7]))
      else $error("pin 7 does not drive its port bit");

   // Upper pins never override the pull-up, so the plain formula must hold
   a_upper_pullups: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE18
      !$past(i_rst) |->
      o_pad.pullup_enable[7:5] == $past(~i_port.direction[7:5] & i_port.port_value[7:5] &
         {3{~i_port.pullup_disable}}))
      else $error("upper pin pull-up not taken from port bits");

   a_ref_pullup_plain: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE2
      !$past(i_rst) && !$past(i_ctrl.reference_select_bit0) |->
      o_pad.pullup_enable[0] == $past(~i_port.direction[0] & i_port.port_value[0] &
         ~i_port.pullup_disable))
      else $error("pin 0 pull-up lost without external reference");

   // Input overrides open or close a pin whatever the sleep state
   a_do_input_off: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE17
      !$past(i_rst) && $past(i_ctrl.analog_input_digital_disable[5]) && !$past(pc_term5) |->
      !o_pad.input_enable[5])
      else $error("pin 5 input not disabled by analog disable bit");

   a_pc6_input_open: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE16
      !$past(i_rst) && $past(pc_term6) |-> o_pad.input_enable[6])
      else $error("pin 6 input closed despite pin-change use");

   a_pc_beats_sleep: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE21
      !$past(i_rst) && $past(i_port.sleep) && $past(pc_term7) |-> o_pad.input_enable[7])
      else $error("pin 7 input clamped in sleep despite pin-change use");

   a_wake_plain: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RULE21
      !$past(i_rst) && !$past(i_port.sleep) &&
      !$past(ovr[3].input_enable_override_enable) |-> o_pad.input_enable[3])
      else $error("pin 3 input closed while awake");

endmodule

// ===== bench/pamx_pad_model.sv
// Pad model for the port A mux: resolves each pin level for the bench.
// Assumes at most one outside source per pin, enabled by i_ext_en.
`timescale 1ns/1ps
module pamx_pad_model
   import pamx_pkg::*;
(
   input wire logic i_core_clk,
   input wire pamx_pad_bus_type i_pad,
   input wire logic [7:0] i_ext_en,
   input wire logic [7:0] i_ext_val,
   output logic [7:0] o_level
);
   logic [7:0] last_q = 8'h00;

   // Mux driver wins, then the outside source, then the pull-up
   // Floating pins show the inverse of the last level, so no stale value passes
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         o_level[n] = !i_pad.output_enable_n[n] ? i_pad.drive[n] :
            i_ext_en[n] ? i_ext_val[n] : i_pad.pullup_enable[n] ? 1'b1 : ~last_q[n];
      end
   end

   // Last level, for the floating case
   always_ff @(posedge i_core_clk) begin
      last_q <= o_level;
   end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the port A alternate function mux.
// Assumes one cycle of latency from inputs to the registered outputs.
`timescale 1ns/1ps
module tb_top
   import pamx_pkg::*;
;
   logic clk;
   logic rst;
   pamx_port_type port_s;
   pamx_ctrl_type ctrl_s;
   pamx_periph_out_type per_s;
   pamx_pad_bus_type pad_w;
   pamx_periph_in_type pin_w;
   logic [7:0] lvl;
   logic [7:0] ext_en;
   logic [7:0] ext_val;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   pamx_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_port(port_s), .i_ctrl(ctrl_s),
      .i_periph(per_s), .i_pad_level(lvl), .o_pad(pad_w), .o_periph(pin_w));
   pamx_pad_model u_pads (.i_core_clk(clk), .i_pad(pad_w), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_level(lvl));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Hang guard, well above the 49 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Two edges, since the pad model loops mux outputs back to the pad inputs
   task automatic apply();
      repeat (2) @(negedge clk);
   endtask

   task automatic idle();
      port_s = '0;
      ctrl_s = '0;
      per_s = '0;
      ext_en = 8'h00;
      ext_val = 8'h00;
   endtask

   task automatic test_route();
      logic [7:0] v;
      idle();
      ext_en = 8'hff; // Comparator pins kept input, pull-up off
      for (int k = 0; k < 2; k++) begin
         v = k ? 8'h56 : 8'ha9;
         ext_val = v;
         apply();
         check("adc", pin_w.converter_channel, v);
         check("pcint", pin_w.pin_change_source, v);
         check("cnt0", pin_w.timer0_count_input, v[3]);
         check("cnt1", pin_w.timer1_count_input, v[4]);
         check("sck", pin_w.serial_clock_three_wire, v[4]);
         check("icp", pin_w.timer1_capture_input, v[7]);
         check("sdi", pin_w.serial_data_in_three_wire, v[6]);
         check("cmp", {pin_w.comparator_negative_input, pin_w.comparator_positive_input},
            v[2:1]);
      end
      $display("done route");
   endtask

   task automatic test_ref();
      idle();
      port_s.port_value = 8'h01;
      port_s.direction = 8'h01;
      ctrl_s.reference_select_bit0 = 1'b1;
      apply();
      check("ref oe", pad_w.output_enable_n[0], 1'b1);
      port_s.direction = 8'h00;
      apply();
      check("ref pu", pad_w.pullup_enable[0], 1'b0);
      ctrl_s.reference_select_bit0 = 1'b0;
      apply();
      check("pu0", pad_w.pullup_enable[0], 1'b1);
      $display("done ref");
   endtask

   task automatic test_pin5();
      idle();
      {ctrl_s.wire_mode_bit1, ctrl_s.wire_mode_bit0} = 2'h1;
      ctrl_s.timer1_compare_b_en = 1'b1;
      port_s.direction = 8'h20;
      for (int k = 1; k >= 0; k--) begin
         per_s.serial_data_out = k[0];
         apply();
         check("do", {pad_w.output_enable_n[5], pad_w.drive[5]}, {1'b0, k[0]});
      end
      port_s.direction = 8'h00;
      port_s.port_value = 8'h20;
      apply();
      check("do in", pad_w.output_enable_n[5], 1'b1);
      check("do pu", pad_w.pullup_enable[5], 1'b1);
      {ctrl_s.wire_mode_bit1, ctrl_s.wire_mode_bit0} = 2'h0;
      per_s.timer1_compare_b_out = 1'b1;
      port_s.direction = 8'h20; // Direction set before compare output
      port_s.port_value = 8'h00;
      apply();
      check("cmp1b", pad_w.drive[5], 1'b1);
      check("cmp1b pad", lvl[5], 1'b1);
      $display("done pin5");
   endtask

   task automatic test_pin6();
      idle();
      ctrl_s.wire_mode_bit1 = 1'b1;
      port_s.direction = 8'h40;
      port_s.port_value = 8'h40;
      apply();
      check("sda low", {pad_w.output_enable_n[6], pad_w.drive[6]}, 2'h0);
      per_s.two_wire_data_out = 1'b1;
      ctrl_s.timer1_compare_a_en = 1'b1;
      per_s.timer1_compare_a_out = 1'b1;
      apply();
      check("sda rel", pad_w.output_enable_n[6], 1'b1);
      port_s.port_value = 8'h00;
      apply();
      check("sda gate", {pad_w.output_enable_n[6], pad_w.drive[6]}, 2'h0);
      port_s.direction = 8'h00;
      apply();
      check("sda dir", pad_w.output_enable_n[6], 1'b1);
      ctrl_s.wire_mode_bit1 = 1'b0;
      port_s.direction = 8'h40; // Direction set before compare output
      apply();
      check("cmp1a", {pad_w.output_enable_n[6], pad_w.drive[6]}, 2'h1);
      port_s.direction = 8'h00;
      port_s.port_value = 8'h40;
      apply();
      check("pu6", pad_w.pullup_enable[6], 1'b1);
      $display("done pin6");
   endtask

   task automatic test_pin7();
      idle();
      ctrl_s.timer0_compare_b_en = 1'b1;
      per_s.timer0_compare_b_out = 1'b1;
      port_s.direction = 8'h80;
      apply();
      check("cmp0b hi", pad_w.drive[7], 1'b1);
      per_s.timer0_compare_b_out = 1'b0;
      port_s.port_value = 8'h80;
      apply();
      check("cmp0b lo", pad_w.drive[7], 1'b0);
      ctrl_s.timer0_compare_b_en = 1'b0;
      apply();
      check("port7", pad_w.drive[7], 1'b1);
      port_s.direction = 8'h00;
      apply();
      check("pu7", pad_w.pullup_enable[7], 1'b1);
      $display("done pin7");
   endtask

   task automatic test_input();
      idle();
      ext_en = 8'hff;
      ext_val = 8'hff;
      port_s.sleep = 1'b1;
      apply();
      check("sleep ie", pad_w.input_enable, 8'h00);
      ctrl_s.start_condition_int_enable = 1'b1;
      apply();
      check("ssie ie", pad_w.input_enable, 8'h50);
      ctrl_s.start_condition_int_enable = 1'b0;
      ctrl_s.pin_change_group0_enable = 1'b1;
      ctrl_s.pin_change_mask = 8'ha0;
      apply();
      check("pc ie", pad_w.input_enable, 8'ha0);
      check("pc src", pin_w.pin_change_source, 8'ha0);
      port_s.sleep = 1'b0;
      ctrl_s.pin_change_mask = 8'h40;
      ctrl_s.analog_input_digital_disable = 8'he0;
      apply();
      check("dis ie", pad_w.input_enable, 8'h5f);
      $display("done input");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Reset for three cycles, then the scenarios in turn
   initial begin
      rst = 1'b1;
      idle();
      repeat (3) @(negedge clk);
      check("rst oe", pad_w.output_enable_n, 8'hff);
      check("rst ie", pad_w.input_enable, 8'h00);
      rst = 1'b0;
      test_route();
      test_ref();
      test_pin5();
      test_pin6();
      test_pin7();
      test_input();
      conclude();
   end
endmodule
